// file: hw/ssr_status_irq.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// How it works
// - status bit 7 mirrors irq output; reset or cause read clears both
// - illegal op events set status bit 6 without raising irq
// - parity error sets bit 5 only when some parity option enabled
// - parity options select internal generation or pass-through parity
// - count zero sets bit 4; nonzero count write or reset clears it
// - dma nop reloads count and clears bit 4; plain nop does not
// - bit 3 set for standard group codes; group 2 valid only with scsi2
// - groups 3,4-reserved six byte; 5 valid ten byte; 6 vendor six, 7 vendor ten
// - bits 6,5,3 clear on cause read or reset
// - status bits 2:0 carry msg, c/d, i/o phase code
// - latch mode captures phase at command end until cause read
// - write-only target id low three bits, untouched by reset
// - cause read clears cause, status bits 7,6,5,3 and sequence step registers
// - bus reset sets cause bit 7 only when report mask enabled
// - bad opcode or wrong mode command sets bit 6 and raises irq
// - disconnect or selection timeout sets cause bit 5
// - atn as target or command steps done as initiator set bit 4
// - successful completions set cause bit 3
// - reselected as initiator sets cause bit 2
// - selected as target sets bit 1 with atn, bit 0 without
// - timeout after value times 8192 times clock factor cycles
// - latch enable lives in control two bit 6
module ssr_status_irq (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic soft_reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // condition events from the sequencer and bus side
  input wire logic [2:0] bus_phase_in,
  input wire logic cmd_end_in,
  input wire logic ioe_dir_in,
  input wire logic ioe_fifo_in,
  input wire logic ioe_phase_in,
  input wire logic ioe_cmd_ovw_in,
  input wire logic par_err_in,
  input wire logic count_zero_in,
  input wire logic count_load_nz_in,
  input wire logic cmd_issue_in,
  input wire logic cmd_dma_in,
  input wire logic [6:0] cmd_code_in,
  input wire logic cmd_bad_in,
  input wire logic cdb_first_in,
  input wire logic [2:0] cdb_group_in,
  input wire logic bus_reset_in,
  input wire logic drop_in,
  input wire logic attn_in,
  input wire logic ok_in,
  input wire logic reconnected_as_initiator_in,
  input wire logic sel_in,
  input wire logic sel_atn_in,
  input wire logic [2:0] step_in,
  input wire logic step_we_in,
  input wire logic sel_wait_in,
  input wire logic sel_resp_in,
  // outputs
  output logic irq_out,
  output logic [2:0] target_id_out,
  output logic sel_timeout_out,
  output logic parity_gen_out,
  output logic cdb_ten_out
);
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [2:0] clock_divisor_factor_q;
  logic [7:0] tmo_q;
  logic [2:0] tid_q;
  logic [7:0] cause_q;
  logic [3:0] stat_q;
  logic [2:0] phase_q;
  logic phase_held_q;
  logic [2:0] step_q;
  logic [31:0] tcnt_q;
  logic [7:0] tunit_q;
  logic resp_q;
  logic tmo_ev;
  logic clr;
  logic wr;
  logic rd;
  logic cause_rd;
  logic [2:0] phase_v;
  logic grp_ok;

  // group code decode, used for valid flag and length
  function automatic logic grp_valid(input logic [2:0] g, input logic s2);
    unique case (g)
      3'h0, 3'h1, 3'h5: grp_valid = 1'b1;
      3'h2: grp_valid = s2;
      default: grp_valid = 1'b0;
    endcase
  endfunction : grp_valid

  function automatic logic grp_ten(input logic [2:0] g, input logic s2);
    unique case (g)
      3'h1, 3'h5, 3'h7: grp_ten = 1'b1;
      3'h2: grp_ten = s2;
      default: grp_ten = 1'b0;
    endcase
  endfunction : grp_ten

  assign clr = !reset_n_in || soft_reset_in;
  assign wr = psel_in && penable_in && pwrite_in;
  assign rd = psel_in && penable_in && !pwrite_in;
  assign cause_rd = rd && paddr_in == ssr_pkg::ADDR_CAUSE;
  assign grp_ok = grp_valid(cdb_group_in, ctrl2_q[ssr_pkg::C2_SCSI2_FEATURES_ON]);
  // latched view while held, else live bus
  assign phase_v = phase_held_q ? phase_q : bus_phase_in;
  // one timeout unit is 8192 times clock factor cycles
  assign tmo_ev = sel_wait_in && tmo_q != 8'h00 && tcnt_q == 32'h0
    && tunit_q == tmo_q;

  // control one: report mask and parity; soft reset keeps it
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ctrl1_q <= ssr_pkg::CTRL_RST;
    end else if (wr && paddr_in == ssr_pkg::ADDR_CTRL1) begin
      ctrl1_q <= pwdata_in[7:0];
    end
  end

  // control two: latch enable, scsi2 and parity options
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ctrl2_q <= ssr_pkg::CTRL_RST;
    end else if (wr && paddr_in == ssr_pkg::ADDR_CTRL2) begin
      ctrl2_q <= pwdata_in[7:0];
    end
  end

  // clock factor scales the timeout unit
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      clock_divisor_factor_q <= ssr_pkg::CLOCK_DIVISOR_FACTOR_RST;
    end else if (wr && paddr_in == ssr_pkg::ADDR_CLOCK_DIVISOR_FACTOR) begin
      clock_divisor_factor_q <= pwdata_in[2:0];
    end
  end

  // timeout value shares the cause offset, write side only
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      tmo_q <= 8'h00;
    end else if (wr && paddr_in == ssr_pkg::ADDR_CAUSE) begin
      tmo_q <= pwdata_in[7:0];
    end
  end

  // target id has no reset: value after power-up is whatever was written
  always_ff @(posedge clk_sys_in) begin
    if (wr && paddr_in == ssr_pkg::ADDR_STATUS) begin
      tid_q <= pwdata_in[2:0];
    end
  end

  // interrupt cause flags; new events win over the read-clear
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      cause_q <= 8'h00;
    end else begin
      if (cause_rd) begin
        cause_q <= 8'h00;
      end
      if (bus_reset_in && ctrl1_q[ssr_pkg::C1_RST_MASK]) begin
        cause_q[ssr_pkg::IC_RST] <= 1'b1;
      end
      if (cmd_bad_in) begin
        cause_q[ssr_pkg::IC_BAD] <= 1'b1;
      end
      if (drop_in || tmo_ev) begin
        cause_q[ssr_pkg::IC_DROP] <= 1'b1;
      end
      if (attn_in) begin
        cause_q[ssr_pkg::IC_ATTN] <= 1'b1;
      end
      if (ok_in) begin
        cause_q[ssr_pkg::IC_OK] <= 1'b1;
      end
      if (reconnected_as_initiator_in) begin
        cause_q[ssr_pkg::IC_RECONNECTED_AS_INITIATOR] <= 1'b1;
      end
      if (sel_in && sel_atn_in) begin
        cause_q[ssr_pkg::IC_CHOSEN_WITH_ATTENTION] <= 1'b1;
      end
      if (sel_in && !sel_atn_in) begin
        cause_q[ssr_pkg::IC_SEL] <= 1'b1;
      end
    end
  end

  // illegal operation flag; a new event wins over the cause read
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      stat_q[3] <= 1'b0;
    end else if (ioe_dir_in || ioe_fifo_in || ioe_phase_in
      || ioe_cmd_ovw_in) begin
      stat_q[3] <= 1'b1;
    end else if (cause_rd) begin
      stat_q[3] <= 1'b0;
    end
  end

  // parity flag counts only while some check option is on
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      stat_q[2] <= 1'b0;
    end else if (par_err_in
      && (ctrl1_q[5:4] != 2'h0 || ctrl2_q[2:0] != 3'h0)) begin
      stat_q[2] <= 1'b1;
    end else if (cause_rd) begin
      stat_q[2] <= 1'b0;
    end
  end

  // group valid flag, judged on the first command byte
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      stat_q[0] <= 1'b0;
    end else if (cdb_first_in && grp_ok) begin
      stat_q[0] <= 1'b1;
    end else if (cause_rd) begin
      stat_q[0] <= 1'b0;
    end
  end

  // count zero flag ignores the cause read
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      stat_q[1] <= 1'b0;
    end else if (count_zero_in) begin
      stat_q[1] <= 1'b1;
    end else if (count_load_nz_in) begin
      stat_q[1] <= 1'b0;
    end else if (cmd_issue_in && cmd_dma_in
      && cmd_code_in == ssr_pkg::CMD_NOP) begin
      stat_q[1] <= 1'b0;
    end
  end

  // phase capture at command end, released by the cause read
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      phase_q <= ssr_pkg::PH_DOUT;
      phase_held_q <= 1'b0;
    end else if (cmd_end_in && ctrl2_q[ssr_pkg::C2_LATCH]) begin
      phase_q <= bus_phase_in;
      phase_held_q <= 1'b1;
    end else if (cause_rd || !ctrl2_q[ssr_pkg::C2_LATCH]) begin
      phase_held_q <= 1'b0;
    end
  end

  // sequence step, cleared by cause read
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      step_q <= 3'h0;
    end else if (step_we_in) begin
      step_q <= step_in;
    end else if (cause_rd) begin
      step_q <= 3'h0;
    end
  end

  // answer seen; keeps the timer stopped for the rest of this wait
  always_ff @(posedge clk_sys_in) begin
    if (clr || !sel_wait_in) begin
      resp_q <= 1'b0;
    end else if (sel_resp_in) begin
      resp_q <= 1'b1;
    end
  end

  // selection timer runs only while waiting for a response
  always_ff @(posedge clk_sys_in) begin
    if (clr || !sel_wait_in || sel_resp_in || resp_q || tmo_ev) begin
      tcnt_q <= 32'h0;
      tunit_q <= 8'h00;
    end else if (tcnt_q == 32'(ssr_pkg::TMO_UNIT) * {29'h0, clock_divisor_factor_q} - 32'h1)
    begin
      tcnt_q <= 32'h0;
      tunit_q <= tunit_q + 8'h01;
    end else begin
      tcnt_q <= tcnt_q + 32'h1;
    end
  end

  // irq follows any pending cause; the read drops it at once
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= cause_q != 8'h00 && !cause_rd;
    end
  end

  // one-cycle timeout pulse for the sequencer
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      sel_timeout_out <= 1'b0;
    end else begin
      sel_timeout_out <= tmo_ev;
    end
  end

  // generate when control two bits 2:0 are all zero, else pass bytes unaltered
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      parity_gen_out <= 1'b0;
    end else begin
      parity_gen_out <= ctrl2_q[2:0] == 3'h0;
    end
  end

  // command block length follows the live group code
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      cdb_ten_out <= 1'b0;
    end else begin
      cdb_ten_out <= grp_ten(cdb_group_in, ctrl2_q[ssr_pkg::C2_SCSI2_FEATURES_ON]);
    end
  end

  // target id copy; shows zero for one cycle after a reset
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      target_id_out <= 3'h0;
    end else begin
      target_id_out <= tid_q;
    end
  end

  // apb answers in the access cycle; unmapped reads return zero
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
      if (psel_in && !penable_in && !pwrite_in) begin
        unique case (paddr_in)
          ssr_pkg::ADDR_STATUS: prdata_out <= {24'h0, irq_out, stat_q,
            phase_v};
          ssr_pkg::ADDR_CAUSE: prdata_out <= {24'h0, cause_q};
          ssr_pkg::ADDR_CTRL1: prdata_out <= {24'h0, ctrl1_q};
          ssr_pkg::ADDR_CTRL2: prdata_out <= {24'h0, ctrl2_q};
          ssr_pkg::ADDR_CLOCK_DIVISOR_FACTOR: prdata_out <= {29'h0, clock_divisor_factor_q};
          ssr_pkg::ADDR_STEP: prdata_out <= {29'h0, step_q};
          default: prdata_out <= 32'h0;
        endcase
      end
    end
  end
endmodule : ssr_status_irq

// file: hw/ssr_pkg.sv
package ssr_pkg;
  // register byte addresses (printed offsets are indices; byte = 4 * index)
  localparam logic [7:0] IDX_STATUS = 8'h04;
  localparam logic [7:0] IDX_CAUSE = 8'h05;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_CAUSE = 12'h014;
  localparam logic [11:0] ADDR_CTRL1 = 12'h040;
  localparam logic [11:0] ADDR_CTRL2 = 12'h044;
  localparam logic [11:0] ADDR_CLOCK_DIVISOR_FACTOR = 12'h048;
  localparam logic [11:0] ADDR_STEP = 12'h04C;
  localparam logic [11:0] ADDR_SETUP = 12'h050;
  // status bit positions
  localparam int ST_IRQ = 7;
  localparam int ST_IOE = 6;
  localparam int ST_PAR = 5;
  localparam int ST_CTZ = 4;
  localparam int ST_GCV = 3;
  // cause bit positions
  localparam int IC_RST = 7;
  localparam int IC_BAD = 6;
  localparam int IC_DROP = 5;
  localparam int IC_ATTN = 4;
  localparam int IC_OK = 3;
  localparam int IC_RECONNECTED_AS_INITIATOR = 2;
  localparam int IC_CHOSEN_WITH_ATTENTION = 1;
  localparam int IC_SEL = 0;
  // control field positions
  localparam int C1_RST_MASK = 6;
  localparam int C1_PAR_LO = 4;
  localparam int C2_LATCH = 6;
  localparam int C2_SCSI2_FEATURES_ON = 3;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] CLOCK_DIVISOR_FACTOR_RST = 3'h2;
  // timeout scale
  localparam int TMO_UNIT = 8192;
  // phase codes (msg, c/d, i/o)
  localparam logic [2:0] PH_DOUT = 3'h0;
  localparam logic [2:0] PH_MSGIN = 3'h7;
  // command opcodes
  localparam logic [6:0] CMD_NOP = 7'h00;
endpackage : ssr_pkg

// file: sim/ssr_status_irq_monitor.sv
`timescale 1ns/1ps
module ssr_status_irq_monitor (
  // clock, reset and bus
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // events and results
  input wire logic attn_in,
  input wire logic cdb_first_in,
  input wire logic [2:0] cdb_group_in,
  input wire logic sel_wait_in,
  input wire logic irq_out,
  input wire logic [2:0] target_id_out,
  input wire logic sel_timeout_out,
  input wire logic parity_gen_out,
  input wire logic cdb_ten_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  logic acc;
  logic s2_q;
  logic [13:0] wait_q;
  assign acc = psel_in && penable_in;
  // scsi2 shadow; controls survive soft reset
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) s2_q <= 1'h0;
    else if (acc && pwrite_in && paddr_in == ssr_pkg::ADDR_CTRL2)
      s2_q <= pwdata_in[ssr_pkg::C2_SCSI2_FEATURES_ON];
  end
  // wait length, saturates so it never wraps
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in || !sel_wait_in) wait_q <= 14'h0000;
    else if (wait_q != 14'h3FFF) wait_q <= wait_q + 14'h0001;
  end
  AST_IRQ_SET: assert property
    ((attn_in && !psel_in) ##1 !psel_in |-> ##1 irq_out)
    else $error("irq missing after attention");
  AST_IRQ_CLR: assert property
    (acc && !pwrite_in && paddr_in == ssr_pkg::ADDR_CAUSE |-> ##2 !irq_out)
    else $error("irq kept after cause read");
  AST_TMO: assert property
    (sel_timeout_out |-> wait_q >= 14'h1FFC && wait_q <= 14'h2008)
    else $error("selection timeout at wrong time");
  AST_PAR_GEN: assert property
    (acc && pwrite_in && paddr_in == ssr_pkg::ADDR_CTRL2
     |-> ##2 parity_gen_out == ($past(pwdata_in[2:0], 2) == 3'h0))
    else $error("parity source wrong");
  AST_CDB_TEN: assert property
    (cdb_first_in |=> cdb_ten_out == ($past(cdb_group_in) inside
     {3'h1, 3'h5, 3'h7} || ($past(cdb_group_in) == 3'h2 && s2_q)))
    else $error("cdb length wrong");
  AST_TID: assert property
    (acc && pwrite_in && paddr_in == ssr_pkg::ADDR_STATUS
     |-> ##2 target_id_out == $past(pwdata_in[2:0], 2))
    else $error("target id not taken");
  AST_PREADY: assert property (acc |-> pready_out)
    else $error("no ready in access");
  AST_NOERR: assert property (pready_out |-> acc && !pslverr_out)
    else $error("stray ready or error");
  cover property (sel_timeout_out);
  cover property (cdb_first_in && s2_q && cdb_group_in == 3'h2);
  cover property (irq_out && acc);
endmodule : ssr_status_irq_monitor
bind ssr_status_irq ssr_status_irq_monitor u_mon (.clk_sys_in, .reset_n_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out,
  .pslverr_out, .attn_in, .cdb_first_in, .cdb_group_in, .sel_wait_in,
  .irq_out, .target_id_out, .sel_timeout_out, .parity_gen_out, .cdb_ten_out);

// file: sim/ssr_far_end.sv
`timescale 1ns/1ps
// far bus device answering a selection, prompt, slow or never
module ssr_far_end (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // wait level and answer setup
  input wire logic sel_wait_in,
  input wire logic resp_en_in,
  input wire logic [15:0] resp_dly_in,
  // answer pulse
  output logic sel_resp_out
);
  logic [15:0] cnt_q;
  // answer after the chosen delay into the wait, and again each time the 16-bit count wraps
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in || !sel_wait_in) begin
      cnt_q <= 16'h0000;
      sel_resp_out <= 1'h0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      sel_resp_out <= resp_en_in && cnt_q == resp_dly_in;
    end
  end
endmodule : ssr_far_end

// file: sim/tb_ssr_status_irq.sv
`timescale 1ns/1ps
module tb_ssr_status_irq;
  logic clk_sys_in = 1'h0, reset_n_in = 1'h0, soft_reset_in = 1'h0;
  logic psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, irq_out, sel_timeout_out, parity_gen_out;
  logic cdb_ten_out, sel_wait_in = 1'h0, sel_resp_in, resp_en = 1'h0;
  logic [2:0] bus_phase_in = 3'h0, target_id_out, cdb_group_in = 3'h0;
  logic [2:0] step_in = 3'h0, ph, tid;
  logic [6:0] cmd_code_in = ssr_pkg::CMD_NOP;
  logic [19:0] ev = 20'h0; // one pulse line per event input
  logic [19:0] cev [8] = '{20'h00800, 20'h00200, 20'h01000, 20'h02000,
    20'h04000, 20'h08000, 20'h30000, 20'h10000};
  int error_cnt = 0, checks_done = 0, n;
  ssr_status_irq dut (.*, .ioe_dir_in(ev[0]), .ioe_fifo_in(ev[1]),
    .ioe_phase_in(ev[2]), .ioe_cmd_ovw_in(ev[3]), .par_err_in(ev[4]),
    .count_zero_in(ev[5]), .count_load_nz_in(ev[6]), .cmd_issue_in(ev[7]),
    .cmd_dma_in(ev[8]), .cmd_bad_in(ev[9]), .cdb_first_in(ev[10]),
    .bus_reset_in(ev[11]), .drop_in(ev[12]), .attn_in(ev[13]),
    .ok_in(ev[14]), .reconnected_as_initiator_in(ev[15]), .sel_in(ev[16]),
    .sel_atn_in(ev[17]), .step_we_in(ev[18]), .cmd_end_in(ev[19]));
  ssr_far_end u_far (.clk_sys_in, .reset_n_in, .sel_wait_in,
    .resp_en_in(resp_en), .resp_dly_in(16'h0064), .sel_resp_out(sel_resp_in));
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'h1;
    do @(posedge clk_sys_in); while (pready_out !== 1'h1);
    rd = prdata_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask : apb
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, {24'h0, e});
  endtask : rc
  task automatic pulse(input logic [19:0] m);
    ev <= m;
    @(posedge clk_sys_in);
    ev <= 20'h0;
    @(posedge clk_sys_in);
  endtask : pulse
  // group codes the status flag accepts
  function automatic logic group_code_ok_flag(input logic [2:0] g, input logic s2);
    return g inside {3'h0, 3'h1, 3'h5} || (g == 3'h2 && s2);
  endfunction : group_code_ok_flag
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // limit of 100k cycles, tests run about 18k cycles
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(50));
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'h1;
    ph = 3'($urandom);
    tid = 3'($urandom);
    bus_phase_in <= ph;
    step_in <= 3'($urandom);
    @(posedge clk_sys_in);
    rc(ssr_pkg::ADDR_STATUS, {5'h0, ph});
    rc(ssr_pkg::ADDR_CAUSE, 8'h00);
    apb(1'h1, ssr_pkg::ADDR_CLOCK_DIVISOR_FACTOR, 32'h1);
    apb(1'h1, ssr_pkg::ADDR_CAUSE, 32'h1);
    apb(1'h1, ssr_pkg::ADDR_CTRL1, 32'h70);
    apb(1'h1, ssr_pkg::ADDR_STATUS, {29'($urandom), tid});
    @(posedge clk_sys_in);
    chk("target id", target_id_out, tid);
    // error flags alone raise no interrupt
    pulse(20'h00470 | (20'h1 << ($urandom % 4)));
    rc(ssr_pkg::ADDR_STATUS, {5'h0F, ph});
    pulse(20'h02000);
    rc(ssr_pkg::ADDR_STATUS, {5'h1F, ph});
    rc(ssr_pkg::ADDR_CAUSE, 8'h10);
    rc(ssr_pkg::ADDR_STATUS, {5'h02, ph});
    pulse(20'h00080);
    rc(ssr_pkg::ADDR_STATUS, {5'h02, ph});
    pulse(20'h00180);
    rc(ssr_pkg::ADDR_STATUS, {5'h00, ph});
    pulse(20'h00020);
    pulse(20'h00040);
    rc(ssr_pkg::ADDR_STATUS, {5'h00, ph});
    for (int i = 0; i < 8; i++) begin
      pulse(cev[i]);
      rc(ssr_pkg::ADDR_CAUSE, 8'h80 >> i);
    end
    apb(1'h1, ssr_pkg::ADDR_CTRL1, 32'h30);
    pulse(20'h00800);
    rc(ssr_pkg::ADDR_CAUSE, 8'h00);
    // latched phase survives a bus change until the cause read
    apb(1'h1, ssr_pkg::ADDR_CTRL2, 32'h40);
    bus_phase_in <= ssr_pkg::PH_MSGIN;
    pulse(20'h80000);
    bus_phase_in <= ssr_pkg::PH_DOUT;
    rc(ssr_pkg::ADDR_STATUS, {5'h00, ssr_pkg::PH_MSGIN});
    rc(ssr_pkg::ADDR_CAUSE, 8'h00);
    rc(ssr_pkg::ADDR_STATUS, {5'h00, ssr_pkg::PH_DOUT});
    for (int i = 0; i < 16; i++) begin
      apb(1'h1, ssr_pkg::ADDR_CTRL2, {28'h0, i[3], 3'($urandom)});
      cdb_group_in <= i[2:0];
      pulse(20'h00400);
      rc(ssr_pkg::ADDR_STATUS, {4'h0, group_code_ok_flag(i[2:0], i[3]), 3'h0});
      rc(ssr_pkg::ADDR_CAUSE, 8'h00);
    end
    // prompt answer stops the count, silence times out
    resp_en <= 1'h1;
    sel_wait_in <= 1'h1;
    repeat (9000) @(posedge clk_sys_in);
    sel_wait_in <= 1'h0;
    rc(ssr_pkg::ADDR_CAUSE, 8'h00);
    resp_en <= 1'h0;
    sel_wait_in <= 1'h1;
    for (n = 0; n < 9000 && sel_timeout_out !== 1'h1; n++)
      @(posedge clk_sys_in);
    sel_wait_in <= 1'h0;
    chk("timeout", n >= 8188 && n <= 8200, 1);
    rc(ssr_pkg::ADDR_CAUSE, 8'h20);
    rc(12'h0FC, 8'h00);
    pulse(20'h40000);
    rc(ssr_pkg::ADDR_STEP, {5'h0, step_in});
    rc(ssr_pkg::ADDR_CAUSE, 8'h00);
    rc(ssr_pkg::ADDR_STEP, 8'h00);
    pulse(20'h02001);
    soft_reset_in <= 1'h1;
    @(posedge clk_sys_in);
    soft_reset_in <= 1'h0;
    @(posedge clk_sys_in);
    rc(ssr_pkg::ADDR_STATUS, 8'h00);
    chk("target id", target_id_out, tid);
    wrap_up();
  end
endmodule : tb_ssr_status_irq
